/* pfwc_ctrl.v */
`timescale 1ns/1ns
`include "pfwc_defs.vh"

// Notes on behaviour
// - Setting go for an erase or row write while the pointer selects a protected location raises the fault flag.
// - An other_reset during a self-programming operation raises the fault flag; rst_n clears it.
// - An interrupted unlock sequence raises the fault flag.
// - Software may set the fault flag for test and must clear it, hardware clears it only on rst_n.
// - With erase select high, go erases the whole row of the pointer and ignores the data pair.
// - An erase or row write aimed at protection while enabled clears go, raises the fault, no flash change.
// - With erase low and load-only high, go copies the data pair into the latch chosen by low pointer bits.
// - With erase and load-only both low, go programs all latches into the addressed row.
// - After a row write every latch returns to the erased value.
module pfwc_ctrl #(
    parameter ROW_WORDS = `PFWC_ROW_WORDS
) (
    input  wire                          clock,
    input  wire                          rst_n,
    // software side
    input  wire                          go_set,
    input  wire                          erase_select,
    input  wire                          latch_load_only,
    input  wire [`PFWC_PTR_HIGH_W-1:0]   flash_pointer_high,
    input  wire [`PFWC_PTR_LOW_W-1:0]    flash_pointer_low,
    input  wire [`PFWC_WORD_HIGH_W-1:0]  flash_word_high,
    input  wire [`PFWC_WORD_LOW_W-1:0]   flash_word_low,
    input  wire                          protect_enable,
    input  wire [`PFWC_ADDR_W-1:0]       protect_limit,
    input  wire                          unlock_abort,
    input  wire                          other_reset,
    input  wire                          fault_set_sw,
    input  wire                          fault_clear_sw,
    output wire                          go_busy,
    output wire                          latches_ready,
    output wire                          program_fault_flag,
    // program flash array side
    output wire                          flash_erase_req,
    output wire                          flash_commit_req,
    output wire [`PFWC_ROW_W-1:0]        flash_row_addr,
    output wire                          flash_load_valid,
    output wire [`PFWC_IDX_W-1:0]        flash_load_index,
    output wire [`PFWC_WORD_W-1:0]       flash_load_data,
    input  wire                          flash_ack
);

    localparam [5:0] S_IDLE   = 6'b000001;
    localparam [5:0] S_LOAD   = 6'b000010;
    localparam [5:0] S_ERASE  = 6'b000100;
    localparam [5:0] S_STREAM = 6'b001000;
    localparam [5:0] S_COMMIT = 6'b010000;
    localparam [5:0] S_CLEAR  = 6'b100000;

    ////////////////////////////////////////////////////////////////////////////////

    reg  [5:0]                 state_q;
    reg  [5:0]                 state_d;
    reg  [`PFWC_IDX_W-1:0]     idx_q;
    reg  [`PFWC_IDX_W-1:0]     idx_d;
    reg                        go_q;
    reg                        go_d;
    reg                        fault_q;
    reg                        erase_req_q;
    reg                        erase_req_d;
    reg                        commit_req_q;
    reg                        commit_req_d;
    reg                        load_valid_q;
    reg  [`PFWC_IDX_W-1:0]     load_idx_q;
    reg  [`PFWC_ADDR_W-1:0]    op_addr_q;
    reg  [`PFWC_ADDR_W-1:0]    op_addr_d;
    reg  [`PFWC_WORD_W-1:0]    data_q;
    reg  [`PFWC_WORD_W-1:0]    data_d;

    wire [`PFWC_ADDR_W-1:0]    pointer;
    wire [`PFWC_WORD_W-1:0]    word_in;
    wire                       idle;
    wire                       accept;
    wire                       flash_op;
    wire                       protected_hit;
    wire                       reject;
    wire                       self_write;
    wire                       mem_wr_en;
    wire [`PFWC_IDX_W-1:0]     mem_wr_addr;
    wire [`PFWC_WORD_W-1:0]    mem_wr_data;
    wire                       mem_rd_en;
    wire                       fault_set;

    assign pointer       = {flash_pointer_high, flash_pointer_low};
    assign word_in       = {flash_word_high, flash_word_low};
    assign idle          = (state_q == S_IDLE);
    assign accept        = go_set & idle & ~other_reset;
    // load-only never touches flash, so protection does not apply to it
    assign flash_op      = erase_select | ~latch_load_only;
    // locations below the limit are the protected region
    assign protected_hit = protect_enable & (pointer < protect_limit);
    assign reject        = accept & flash_op & protected_hit;
    assign self_write    = (state_q == S_ERASE) | (state_q == S_STREAM) | (state_q == S_COMMIT);

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer

    always @* begin
        state_d      = state_q;
        idx_d        = idx_q;
        go_d         = go_q;
        erase_req_d  = erase_req_q;
        commit_req_d = commit_req_q;
        op_addr_d    = op_addr_q;
        data_d       = data_q;
        case (state_q)
            S_IDLE: begin
                if (reject) begin
                    go_d = 1'b0;
                end else if (accept) begin
                    go_d      = 1'b1;
                    op_addr_d = pointer;
                    if (erase_select) begin
                        erase_req_d = 1'b1;
                        state_d     = S_ERASE;
                    end else if (latch_load_only) begin
                        data_d  = word_in;
                        state_d = S_LOAD;
                    end else begin
                        idx_d   = `PFWC_IDX_ZERO;
                        state_d = S_STREAM;
                    end
                end
            end
            S_LOAD: begin
                go_d    = 1'b0;
                state_d = S_IDLE;
            end
            S_ERASE: begin
                if (flash_ack) begin
                    erase_req_d = 1'b0;
                    go_d        = 1'b0;
                    state_d     = S_IDLE;
                end
            end
            S_STREAM: begin
                if (idx_q == `PFWC_IDX_LAST) begin
                    state_d = S_COMMIT;
                end else begin
                    idx_d = idx_q + `PFWC_IDX_ONE;
                end
            end
            S_COMMIT: begin
                // request waits one cycle so the last latch word lands first
                if (!commit_req_q) begin
                    commit_req_d = 1'b1;
                end else if (flash_ack) begin
                    commit_req_d = 1'b0;
                    idx_d        = `PFWC_IDX_ZERO;
                    state_d      = S_CLEAR;
                end
            end
            S_CLEAR: begin
                if (idx_q == `PFWC_IDX_LAST) begin
                    go_d    = 1'b0;
                    state_d = S_IDLE;
                end else begin
                    idx_d = idx_q + `PFWC_IDX_ONE;
                end
            end
            default: begin
                state_d = S_IDLE;
                go_d    = 1'b0;
            end
        endcase
        // any other reset aborts the sequence and erases the latches again
        if (other_reset) begin
            state_d      = S_CLEAR;
            idx_d        = `PFWC_IDX_ZERO;
            go_d         = 1'b0;
            erase_req_d  = 1'b0;
            commit_req_d = 1'b0;
        end
    end

    // after power-up the latches hold garbage, so start by clearing them
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q      <= S_CLEAR;
            idx_q        <= `PFWC_IDX_ZERO;
            go_q         <= 1'b0;
            erase_req_q  <= 1'b0;
            commit_req_q <= 1'b0;
            op_addr_q    <= {`PFWC_ADDR_W{1'b0}};
            data_q       <= {`PFWC_WORD_W{1'b0}};
            load_valid_q <= 1'b0;
            load_idx_q   <= `PFWC_IDX_ZERO;
        end else begin
            state_q      <= state_d;
            idx_q        <= idx_d;
            go_q         <= go_d;
            erase_req_q  <= erase_req_d;
            commit_req_q <= commit_req_d;
            op_addr_q    <= op_addr_d;
            data_q       <= data_d;
            load_valid_q <= mem_rd_en & ~other_reset;
            load_idx_q   <= idx_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fault flag: set wins over the software clear

    assign fault_set = reject
                     | (other_reset & self_write)
                     | unlock_abort
                     | fault_set_sw;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault_set | (fault_q & ~fault_clear_sw);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // write latches

    assign mem_wr_en   = (state_q == S_LOAD) | (state_q == S_CLEAR);
    assign mem_wr_addr = (state_q == S_LOAD) ? op_addr_q[`PFWC_IDX_W-1:0] : idx_q;
    assign mem_wr_data = (state_q == S_LOAD) ? data_q : `PFWC_ERASED_WORD;
    assign mem_rd_en   = (state_q == S_STREAM);

    pfwc_latch_mem #(
        .DW (`PFWC_WORD_W),
        .AW (`PFWC_IDX_W)
    ) u_latches (
        .clock   (clock),
        .rst_n   (rst_n),
        .wr_en   (mem_wr_en),
        .wr_addr (mem_wr_addr),
        .wr_data (mem_wr_data),
        .rd_en   (mem_rd_en),
        .rd_addr (idx_q),
        .rd_data (flash_load_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign go_busy            = go_q;
    assign latches_ready      = idle;
    assign program_fault_flag = fault_q;
    assign flash_erase_req    = erase_req_q;
    assign flash_commit_req   = commit_req_q;
    assign flash_row_addr     = op_addr_q[`PFWC_ADDR_W-1:`PFWC_IDX_W];
    assign flash_load_valid   = load_valid_q;
    assign flash_load_index   = load_idx_q;

endmodule // pfwc_ctrl

/* pfwc_defs.vh */
`ifndef PFWC_DEFS_VH
`define PFWC_DEFS_VH

// words in one flash row and the index width that selects one of them
`define PFWC_ROW_WORDS      32
`define PFWC_IDX_W          5
`define PFWC_IDX_LAST       5'h1f
`define PFWC_IDX_ZERO       5'h00
`define PFWC_IDX_ONE        5'h01

// flash word and pointer geometry
`define PFWC_WORD_W         14
`define PFWC_PTR_HIGH_W     7
`define PFWC_PTR_LOW_W      8
`define PFWC_WORD_HIGH_W    6
`define PFWC_WORD_LOW_W     8
`define PFWC_ADDR_W         15
`define PFWC_ROW_W          10

// value a write latch holds when it has not been loaded
`define PFWC_ERASED_WORD    14'h03ff

`endif

/* pfwc_latch_mem.v */
`timescale 1ns/1ns

module pfwc_latch_mem #(
    parameter DW = 14,
    parameter AW = 5
) (
    input  wire          clock,
    input  wire          rst_n,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    input  wire          rd_en,
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // array itself has no reset; owner clears it by walking the addresses
    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= {DW{1'b0}};
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // pfwc_latch_mem

/* pfwc_ctrl_props.sv */
`timescale 1ns/1ns
module pfwc_ctrl_props (
    input logic        clock,
    input logic        rst_n,
    input logic        go_set,
    input logic        erase_select,
    input logic        latch_load_only,
    input logic [6:0]  flash_pointer_high,
    input logic [7:0]  flash_pointer_low,
    input logic        protect_enable,
    input logic [14:0] protect_limit,
    input logic        unlock_abort,
    input logic        other_reset,
    input logic        fault_set_sw,
    input logic        fault_clear_sw,
    input logic        go_busy,
    input logic        latches_ready,
    input logic        program_fault_flag,
    input logic        flash_erase_req,
    input logic        flash_commit_req,
    input logic [9:0]  flash_row_addr,
    input logic        flash_load_valid,
    input logic [4:0]  flash_load_index,
    input logic        flash_ack
);
    ////////////////////////////////////////////////////////////
    wire [14:0] ptr  = {flash_pointer_high, flash_pointer_low};
    wire        acc  = go_set && latches_ready && !other_reset;
    wire        prot = protect_enable && (ptr < protect_limit);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_take_write;
        acc && !erase_select && !latch_load_only && !prot;
    endsequence
    sequence s_first_load;
        go_busy ##1 (flash_load_valid && flash_load_index == 5'h00);
    endsequence
    property p_reject;
        acc && prot && (erase_select || !latch_load_only)
            |=> program_fault_flag && !go_busy && !flash_erase_req;
    endproperty
    property p_set;
        fault_set_sw || unlock_abort |=> program_fault_flag;
    endproperty
    property p_sticky;
        program_fault_flag && !fault_clear_sw |=> program_fault_flag;
    endproperty
    property p_load;
        acc && !erase_select && latch_load_only
            |=> go_busy && !flash_erase_req && !flash_commit_req ##1 !go_busy;
    endproperty
    property p_erase;
        acc && erase_select && !prot
            |=> flash_erase_req && go_busy && flash_row_addr == $past(ptr[14:5]);
    endproperty
    property p_erase_done;
        flash_erase_req && flash_ack && !other_reset |=> !flash_erase_req && !go_busy;
    endproperty
    property p_reset_fault;
        other_reset && (flash_erase_req || flash_commit_req) |=> program_fault_flag;
    endproperty
    property p_write;
        // another reset in the first stream cycle legally cancels the stream
        s_take_write ##1 !other_reset |-> s_first_load;
    endproperty
    property p_commit_done;
        flash_commit_req && flash_ack && !other_reset |=> !flash_commit_req && go_busy;
    endproperty
    a_reject: assert property (p_reject)
        else $error("protected request not refused");
    a_set: assert property (p_set)
        else $error("fault flag not set");
    a_sticky: assert property (p_sticky)
        else $error("fault flag cleared by hardware");
    a_load: assert property (p_load)
        else $error("latch load misbehaved");
    a_erase: assert property (p_erase)
        else $error("erase request or row wrong");
    a_erase_done: assert property (p_erase_done)
        else $error("go not cleared after erase");
    a_reset_fault: assert property (p_reset_fault)
        else $error("reset during operation not flagged");
    a_write: assert property (p_write)
        else $error("row write stream did not start");
    a_commit_done: assert property (p_commit_done)
        else $error("commit not followed by latch clear");
endmodule // pfwc_ctrl_props

bind pfwc_ctrl pfwc_ctrl_props u_props (.*);

/* pfwc_flash_model.sv */
`timescale 1ns/1ns
module pfwc_flash_model (
    input  logic        clock,
    input  logic        rst_n,
    input  logic        erase_req,
    input  logic        commit_req,
    input  logic [9:0]  row_addr,
    input  logic        load_valid,
    input  logic [4:0]  load_index,
    input  logic [13:0] load_data,
    input  logic [7:0]  ack_delay,
    output logic        ack
);
    ////////////////////////////////////////////////////////////
    logic [13:0] row_q [0:31];
    logic [9:0]  erase_row_q;
    logic [7:0]  erases_q;
    logic [7:0]  cnt_q;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            cnt_q <= 8'h00;
            erases_q <= 8'h00;
            erase_row_q <= 10'h000;
        end else begin
            ack <= 1'b0;
            if (load_valid) begin
                row_q[load_index] <= load_data;
            end
            // a dropped request restarts the wait
            if ((erase_req || commit_req) && !ack) begin
                cnt_q <= cnt_q + 8'h01;
                if (cnt_q == ack_delay) begin
                    ack <= 1'b1;
                    if (erase_req) begin
                        erases_q <= erases_q + 8'h01;
                        erase_row_q <= row_addr;
                    end
                end
            end else begin
                cnt_q <= 8'h00;
            end
        end
    end
endmodule // pfwc_flash_model

/* program_flash_write_control_tb_top.sv */
`timescale 1ns/1ns
module program_flash_write_control_tb_top;
    logic        clock, rst_n, go_set, erase_select, latch_load_only, protect_enable;
    logic        unlock_abort, other_reset, fault_set_sw, fault_clear_sw, flash_ack;
    logic        go_busy, latches_ready, program_fault_flag, flash_erase_req;
    logic        flash_commit_req, flash_load_valid;
    logic [14:0] ptr, protect_limit;
    logic [13:0] wdata, flash_load_data;
    logic [9:0]  flash_row_addr;
    logic [4:0]  flash_load_index;
    logic [7:0]  ack_delay;
    int          errors, checked, i;
    pfwc_ctrl u_pfwc_ctrl (.clock(clock), .rst_n(rst_n), .go_set(go_set),
        .erase_select(erase_select), .latch_load_only(latch_load_only),
        .flash_pointer_high(ptr[14:8]), .flash_pointer_low(ptr[7:0]),
        .flash_word_high(wdata[13:8]), .flash_word_low(wdata[7:0]),
        .protect_enable(protect_enable), .protect_limit(protect_limit),
        .unlock_abort(unlock_abort), .other_reset(other_reset),
        .fault_set_sw(fault_set_sw), .fault_clear_sw(fault_clear_sw), .go_busy(go_busy),
        .latches_ready(latches_ready), .program_fault_flag(program_fault_flag),
        .flash_erase_req(flash_erase_req), .flash_commit_req(flash_commit_req),
        .flash_row_addr(flash_row_addr), .flash_load_valid(flash_load_valid),
        .flash_load_index(flash_load_index), .flash_load_data(flash_load_data),
        .flash_ack(flash_ack));
    pfwc_flash_model u_pfwc_flash_model (.clock(clock), .rst_n(rst_n),
        .erase_req(flash_erase_req), .commit_req(flash_commit_req),
        .row_addr(flash_row_addr), .load_valid(flash_load_valid),
        .load_index(flash_load_index), .load_data(flash_load_data),
        .ack_delay(ack_delay), .ack(flash_ack));
    ////////////////////////////////////////////////////////////
    task test_done;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task cmp(input string name, input logic [13:0] exp, input logic [13:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // bounded so a stuck sequencer ends the run
    task wait_idle;
        int n;
        n = 0;
        @(negedge clock);
        while (latches_ready !== 1'b1) begin
            n++;
            if (n > 400) begin
                errors++;
                test_done;
            end
            @(negedge clock);
        end
    endtask
    task req(input logic er, input logic lw, input logic [14:0] a, input logic [13:0] d);
        wait_idle;
        erase_select = er;
        latch_load_only = lw;
        ptr = a;
        wdata = d;
        go_set = 1'b1;
        @(negedge clock);
        go_set = 1'b0;
        @(negedge clock);
    endtask
    task flag(input logic s, input logic a, input logic c, input logic e);
        fault_set_sw = s;
        unlock_abort = a;
        fault_clear_sw = c;
        @(negedge clock);
        {fault_set_sw, unlock_abort, fault_clear_sw} = 3'h0;
        cmp("fault_flag", {13'h0, e}, {13'h0, program_fault_flag});
    endtask
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial begin
        {rst_n, go_set, erase_select, latch_load_only, unlock_abort} = 5'h0;
        {other_reset, fault_set_sw, fault_clear_sw} = 3'h0;
        ptr = 15'h0000;
        wdata = 14'h0000;
        errors = 0;
        checked = 0;
        ack_delay = 8'h03;
        protect_enable = 1'b1;
        protect_limit = 15'h0100;
        repeat (8) @(negedge clock);
        rst_n = 1'b1;
        wait_idle;
        cmp("fault_reset", 14'h0, program_fault_flag);
        req(1'b0, 1'b1, 15'h0023, 14'h2a5c);
        req(1'b0, 1'b1, 15'h043f, 14'h0155);
        cmp("fault_load", 14'h0, program_fault_flag);
        req(1'b0, 1'b0, 15'h0420, 14'h3fff);
        wait_idle;
        cmp("word3", 14'h2a5c, u_pfwc_flash_model.row_q[3]);
        cmp("word31", 14'h0155, u_pfwc_flash_model.row_q[31]);
        cmp("word0", 14'h03ff, u_pfwc_flash_model.row_q[0]);
        req(1'b0, 1'b0, 15'h0420, 14'h0000);
        wait_idle;
        cmp("word3_erased", 14'h03ff, u_pfwc_flash_model.row_q[3]);
        ack_delay = 8'h14;
        req(1'b1, 1'b0, 15'h0c55, 14'h1111);
        wait_idle;
        cmp("erases", 14'h1, u_pfwc_flash_model.erases_q);
        cmp("erase_row", 14'h062, u_pfwc_flash_model.erase_row_q);
        for (i = 0; i < 2; i++) begin
            req(i == 0, 1'b0, 15'h0040, 14'h0000);
            cmp("go_reject", 14'h0, go_busy);
            cmp("fault_reject", 14'h1, program_fault_flag);
            flag(1'b0, 1'b0, 1'b1, 1'b0);
        end
        cmp("erases_reject", 14'h1, u_pfwc_flash_model.erases_q);
        flag(1'b1, 1'b0, 1'b0, 1'b1);
        repeat (3) @(negedge clock);
        flag(1'b0, 1'b0, 1'b0, 1'b1);
        flag(1'b0, 1'b0, 1'b1, 1'b0);
        flag(1'b0, 1'b1, 1'b0, 1'b1);
        flag(1'b0, 1'b0, 1'b1, 1'b0);
        // abort and clear in one cycle: the set must win
        flag(1'b0, 1'b1, 1'b1, 1'b1);
        flag(1'b0, 1'b0, 1'b1, 1'b0);
        req(1'b1, 1'b0, 15'h0c55, 14'h0000);
        cmp("go_erase", 14'h1, go_busy);
        repeat (4) @(negedge clock);
        other_reset = 1'b1;
        @(negedge clock);
        other_reset = 1'b0;
        wait_idle;
        cmp("fault_midreset", 14'h1, program_fault_flag);
        test_done;
    end
endmodule // program_flash_write_control_tb_top
